// >>> rtl/startup_cfg_reg.sv
// Top: AXI4-Lite slave holding the open-loop startup settings register and its decoded values
//
// The AXI4-Lite interface to the registers was decided locally.
`default_nettype none
module startup_cfg_reg
	import startup_cfg_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [startup_cfg_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [startup_cfg_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Decoded startup settings
	output logic parityBit,
	output logic [15:0] openLoopCurrentCapMilliamp,
	output logic [23:0] openLoopAccelLinearCenti,
	output logic [23:0] openLoopAccelQuadraticCenti,
	output logic autoHandoffEn,
	output logic thresholdHandoffEn,
	output logic [startup_cfg_pkg::THRESHOLD_W-1:0] loopTransferSpeedThreshold
);
	import startup_cfg_pkg::*;

	cfg_word_if wordBus ();

	cfg_word_store u_store (
		.sys_clk(sys_clk),
		.rst(rst),
		.port(wordBus)
	);

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	// Address and data are latched independently so either may come first.
	logic awHeld;
	logic wHeld;
	logic [ADDR_W-1:0] awAddrHeld;
	logic [31:0] wDataHeld;
	logic [3:0] wStrbHeld;

	wire awTake = awvalid && awready;
	wire wTake = wvalid && wready;
	wire writeFire = awHeld && wHeld && !bvalid;
	wire writeHit = (awAddrHeld == STARTUP_TWO_OFFSET);

	assign awready = !awHeld && !bvalid;
	assign wready = !wHeld && !bvalid;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			awHeld <= 1'b0;
			awAddrHeld <= '0;
		end else if (awTake) begin
			awHeld <= 1'b1;
			awAddrHeld <= awaddr;
		end else if (writeFire) begin
			awHeld <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wHeld <= 1'b0;
			wDataHeld <= '0;
			wStrbHeld <= '0;
		end else if (wTake) begin
			wHeld <= 1'b1;
			wDataHeld <= wdata;
			wStrbHeld <= wstrb;
		end else if (writeFire) begin
			wHeld <= 1'b0;
		end
	end

	assign wordBus.writeEn = writeFire && writeHit;
	assign wordBus.writeData = wDataHeld;
	assign wordBus.writeStrb = wStrbHeld;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (writeFire) begin
			bvalid <= 1'b1;
			bresp <= writeHit ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	wire arTake = arvalid && arready;
	wire readHit = (araddr == STARTUP_TWO_OFFSET);
	wire [31:0] readWord = readHit ? wordBus.word : READ_UNMAPPED;

	assign arready = !rvalid;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arTake) begin
			rvalid <= 1'b1;
			rdata <= readWord;
			rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	wire [31:0] cfg = wordBus.word;
	wire [CODE_W-1:0] capCode = cfg[CURRENT_CAP_LSB +: CODE_W];
	wire [CODE_W-1:0] linCode = cfg[ACCEL_LIN_LSB +: CODE_W];
	wire [CODE_W-1:0] quadCode = cfg[ACCEL_QUAD_LSB +: CODE_W];
	// Quadratic table differs from the linear one only at code zero.
	wire [23:0] quadValue = (quadCode == 4'h0) ? QUAD_ZERO_CENTI : ACCEL_CENTI[quadCode];

	// Registered so downstream timing never sees the table muxes.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			parityBit <= 1'b0;
			openLoopCurrentCapMilliamp <= CURRENT_CAP_MA[0];
			openLoopAccelLinearCenti <= ACCEL_CENTI[0];
			openLoopAccelQuadraticCenti <= QUAD_ZERO_CENTI;
			autoHandoffEn <= 1'b0;
			thresholdHandoffEn <= 1'b1;
			loopTransferSpeedThreshold <= '0;
		end else begin
			parityBit <= cfg[PARITY_POS];
			openLoopCurrentCapMilliamp <= CURRENT_CAP_MA[capCode];
			openLoopAccelLinearCenti <= ACCEL_CENTI[linCode];
			openLoopAccelQuadraticCenti <= quadValue;
			autoHandoffEn <= cfg[AUTO_HANDOFF_POS];
			thresholdHandoffEn <= !cfg[AUTO_HANDOFF_POS];
			loopTransferSpeedThreshold <= cfg[THRESHOLD_LSB +: THRESHOLD_W];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_reset_reads_zero;
		@(posedge sys_clk) $fell(rst) |-> (wordBus.word == 32'h00000000);
	endproperty
	a_reset_reads_zero: assert property (p_reset_reads_zero) else $error("word not zero after reset");

	property p_read_hit_returns_word;
		@(posedge sys_clk) disable iff (rst)
		(arTake && readHit && !writeFire) |=> (rvalid && rdata == $past(wordBus.word) && rresp == RESP_OKAY);
	endproperty
	a_read_hit_returns_word: assert property (p_read_hit_returns_word) else $error("read data mismatch");

	property p_miss_write_no_change;
		@(posedge sys_clk) disable iff (rst)
		(writeFire && !writeHit) |=> (wordBus.word == $past(wordBus.word)) && bresp == RESP_SLVERR;
	endproperty
	a_miss_write_no_change: assert property (p_miss_write_no_change) else $error("unmapped write changed word");

	property p_parity_writes;
		@(posedge sys_clk) disable iff (rst)
		(wordBus.writeEn && wStrbHeld[3]) |=> ##1 (parityBit == $past(wDataHeld[31], 2));
	endproperty
	a_parity_writes: assert property (p_parity_writes) else $error("parity bit not written");

	property p_cap_decode;
		@(posedge sys_clk) disable iff (rst)
		(capCode == 4'hF) |=> (openLoopCurrentCapMilliamp == 16'h1F40);
	endproperty
	a_cap_decode: assert property (p_cap_decode) else $error("current cap 8 A decode wrong");

	property p_lin_decode;
		@(posedge sys_clk) disable iff (rst)
		(linCode == 4'h0) |=> (openLoopAccelLinearCenti == 24'h000001);
	endproperty
	a_lin_decode: assert property (p_lin_decode) else $error("linear accel code 0 decode wrong");

	property p_quad_decode;
		@(posedge sys_clk) disable iff (rst)
		(quadCode == 4'h0) |=> (openLoopAccelQuadraticCenti == 24'h000000);
	endproperty
	a_quad_decode: assert property (p_quad_decode) else $error("quadratic accel code 0 decode wrong");

	property p_handoff_exclusive;
		@(posedge sys_clk) disable iff (rst)
		(autoHandoffEn != thresholdHandoffEn) && ($past(cfg[18]) == autoHandoffEn);
	endproperty
	a_handoff_exclusive: assert property (p_handoff_exclusive) else $error("handoff mode mismatch");

	property p_threshold_follows;
		@(posedge sys_clk) disable iff (rst)
		$changed(cfg[17:13]) |=> (loopTransferSpeedThreshold == $past(cfg[17:13]));
	endproperty
	a_threshold_follows: assert property (p_threshold_follows) else $error("threshold not tracked");

	property p_reset_bus_idle;
		@(posedge sys_clk) $fell(rst) |-> (!bvalid && !rvalid && awready && wready && arready);
	endproperty
	a_reset_bus_idle: assert property (p_reset_bus_idle) else $error("bus not idle after reset");

	property p_reset_decode_idle;
		@(posedge sys_clk) $fell(rst) |-> (openLoopCurrentCapMilliamp == 16'h007D && !autoHandoffEn && thresholdHandoffEn);
	endproperty
	a_reset_decode_idle: assert property (p_reset_decode_idle) else $error("decode not idle after reset");

	property p_full_write_lands;
		@(posedge sys_clk) disable iff (rst)
		(wordBus.writeEn && wStrbHeld == 4'hF) |=> (wordBus.word == $past(wDataHeld));
	endproperty
	a_full_write_lands: assert property (p_full_write_lands) else $error("full word write lost");

	property p_masked_byte_kept;
		@(posedge sys_clk) disable iff (rst)
		(wordBus.writeEn && !wStrbHeld[0]) |=> (wordBus.word[7:0] == $past(wordBus.word[7:0]));
	endproperty
	a_masked_byte_kept: assert property (p_masked_byte_kept) else $error("masked byte changed");

	property p_write_hit_okay;
		@(posedge sys_clk) disable iff (rst)
		(writeFire && writeHit) |=> (bvalid && bresp == RESP_OKAY);
	endproperty
	a_write_hit_okay: assert property (p_write_hit_okay) else $error("mapped write not answered okay");

	property p_write_answer_time;
		@(posedge sys_clk) disable iff (rst)
		(awTake && wTake) |=> ##1 bvalid;
	endproperty
	a_write_answer_time: assert property (p_write_answer_time) else $error("write answer late");

	property p_read_miss_zero;
		@(posedge sys_clk) disable iff (rst)
		(arTake && !readHit) |=> (rvalid && rdata == READ_UNMAPPED && rresp == RESP_SLVERR);
	endproperty
	a_read_miss_zero: assert property (p_read_miss_zero) else $error("unmapped read answer wrong");

	property p_parity_kept;
		@(posedge sys_clk) disable iff (rst)
		(wordBus.writeEn && !wStrbHeld[3]) |=> ##1 (parityBit == $past(parityBit));
	endproperty
	a_parity_kept: assert property (p_parity_kept) else $error("masked parity bit changed");

	property p_cap_mid_decode;
		@(posedge sys_clk) disable iff (rst)
		(capCode == 4'h4) |=> (openLoopCurrentCapMilliamp == 16'h05DC);
	endproperty
	a_cap_mid_decode: assert property (p_cap_mid_decode) else $error("current cap 1.5 A decode wrong");

	property p_cap_step_decode;
		@(posedge sys_clk) disable iff (rst)
		(capCode == 4'hE) |=> (openLoopCurrentCapMilliamp == 16'h1B58);
	endproperty
	a_cap_step_decode: assert property (p_cap_step_decode) else $error("current cap 7 A decode wrong");

	property p_lin_mid_decode;
		@(posedge sys_clk) disable iff (rst)
		(linCode == 4'hA) |=> (openLoopAccelLinearCenti == 24'h0061A8);
	endproperty
	a_lin_mid_decode: assert property (p_lin_mid_decode) else $error("linear accel code A decode wrong");

	property p_quad_low_decode;
		@(posedge sys_clk) disable iff (rst)
		(quadCode == 4'h1) |=> (openLoopAccelQuadraticCenti == 24'h000005);
	endproperty
	a_quad_low_decode: assert property (p_quad_low_decode) else $error("quadratic accel code 1 decode wrong");

	property p_auto_handoff_set;
		@(posedge sys_clk) disable iff (rst)
		cfg[AUTO_HANDOFF_POS] |=> (autoHandoffEn && !thresholdHandoffEn);
	endproperty
	a_auto_handoff_set: assert property (p_auto_handoff_set) else $error("auto handoff not selected");
endmodule : startup_cfg_reg
`default_nettype wire

// >>> rtl/startup_cfg_pkg.sv
// Package: register map, field layout and decode tables of the startup settings register
`default_nettype none
package startup_cfg_pkg;
	localparam int ADDR_W = 10;
	// Word index; each index is one aligned word, so the byte address is four times it
	localparam logic [7:0] STARTUP_TWO_INDEX = 8'h86;
	localparam logic [ADDR_W-1:0] STARTUP_TWO_OFFSET = {STARTUP_TWO_INDEX, 2'b00};
	localparam logic [31:0] STARTUP_TWO_RESET = 32'h00000000;
	localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
	localparam int PARITY_POS = 31;
	localparam int CURRENT_CAP_LSB = 27;
	localparam int ACCEL_LIN_LSB = 23;
	localparam int ACCEL_QUAD_LSB = 19;
	localparam int AUTO_HANDOFF_POS = 18;
	localparam int THRESHOLD_LSB = 13;
	localparam int THRESHOLD_W = 5;
	localparam int CODE_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Current cap in mA, indexed by code
	localparam logic [15:0] CURRENT_CAP_MA [16] = '{
		16'h007D, 16'h00FA, 16'h01F4, 16'h03E8, 16'h05DC, 16'h07D0, 16'h09C4, 16'h0BB8,
		16'h0DAC, 16'h0FA0, 16'h1194, 16'h1388, 16'h157C, 16'h1770, 16'h1B58, 16'h1F40};
	// Acceleration in hundredths of Hz/s (or Hz/s2), indexed by code
	localparam logic [23:0] ACCEL_CENTI [16] = '{
		24'h000001, 24'h000005, 24'h000064, 24'h0000FA, 24'h0001F4, 24'h0003E8, 24'h0009C4, 24'h001388,
		24'h001D4C, 24'h002710, 24'h0061A8, 24'h00C350, 24'h0124F8, 24'h0186A0, 24'h07A120, 24'h0F4240};
	localparam logic [23:0] QUAD_ZERO_CENTI = 24'h000000;
endpackage : startup_cfg_pkg
`default_nettype wire

// >>> rtl/cfg_word_if.sv
// Interface: register write strobe, data and stored word between the slave and the storage
`default_nettype none
interface cfg_word_if;
	logic writeEn;
	logic [31:0] writeData;
	logic [3:0] writeStrb;
	logic [31:0] word;
	modport bus (output writeEn, output writeData, output writeStrb, input word);
	modport store (input writeEn, input writeData, input writeStrb, output word);
endinterface : cfg_word_if
`default_nettype wire

// >>> rtl/cfg_word_store.sv
// Storage: one 32-bit word with byte enables, reset to the package value
`default_nettype none
module cfg_word_store
	import startup_cfg_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Word port
	cfg_word_if.store port
);
	logic [31:0] word;
	logic [31:0] next_word;

	always_comb begin
		next_word = word;
		for (int b = 0; b < 4; b++) begin
			if (port.writeEn && port.writeStrb[b]) begin
				next_word[b*8 +: 8] = port.writeData[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			word <= STARTUP_TWO_RESET;
		end else begin
			word <= next_word;
		end
	end

	assign port.word = word;
endmodule : cfg_word_store
`default_nettype wire

// >>> sim/tb.sv
// Testbench: AXI4-Lite driver and reference model for the startup settings register
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %s exp=%0h got=%0h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import startup_cfg_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	wire logic awready, wready, bvalid, arready, rvalid, parityBit, autoHandoffEn, thresholdHandoffEn;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [15:0] openLoopCurrentCapMilliamp;
	wire logic [23:0] openLoopAccelLinearCenti, openLoopAccelQuadraticCenti;
	wire logic [4:0] loopTransferSpeedThreshold;
	int bad_count = 0;
	int num_checks = 0;
	logic [31:0] seed = 32'h000032BE;
	logic [31:0] modelWord = 32'h00000000;
	// Acceleration in hundredths, code order
	int accTab [16] = '{1, 5, 100, 250, 500, 1000, 2500, 5000, 7500, 10000, 25000, 50000, 75000, 100000,
		500000, 1000000};
	always #4 sys_clk = ~sys_clk;
	startup_cfg_reg u_dut (.sys_clk, .rst, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
		.wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid, .rready, .rdata,
		.rresp, .parityBit, .openLoopCurrentCapMilliamp, .openLoopAccelLinearCenti,
		.openLoopAccelQuadraticCenti, .autoHandoffEn, .thresholdHandoffEn, .loopTransferSpeedThreshold);
	function automatic logic [31:0] xs;
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// Bus tasks: ready sampled at the falling edge, so no race with the rising edge
	// ----------------------------------------
	task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ta, tw, b;
		logic [1:0] rs;
		int n;
		ta = 1'b0; tw = 1'b0; b = 1'b0; n = 0;
		awaddr <= a; awprot <= d[2:0]; wdata <= d; wstrb <= s;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (!b && n < 50) begin
			@(negedge sys_clk);
			ta = awvalid && awready; tw = wvalid && wready; b = bvalid; rs = bresp;
			@(posedge sys_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			n++;
		end
		if (!b) begin
			bad_count++;
			wrap_up;
		end
		bready <= 1'b0;
		`CHK("bresp", (a == STARTUP_TWO_OFFSET) ? RESP_OKAY : RESP_SLVERR, rs)
		if (a == STARTUP_TWO_OFFSET) begin
			for (int i = 0; i < 4; i++) if (s[i]) modelWord[8*i +: 8] = d[8*i +: 8];
		end
	endtask : axi_write
	task automatic axi_read(input logic [ADDR_W-1:0] a);
		logic t, v;
		logic [31:0] rd;
		logic [1:0] rs;
		int n;
		t = 1'b0; v = 1'b0; n = 0;
		araddr <= a; arprot <= a[2:0]; arvalid <= 1'b1; rready <= 1'b1;
		while (!v && n < 50) begin
			@(negedge sys_clk);
			t = arvalid && arready; v = rvalid; rd = rdata; rs = rresp;
			@(posedge sys_clk);
			if (t) arvalid <= 1'b0;
			n++;
		end
		if (!v) begin
			bad_count++;
			wrap_up;
		end
		rready <= 1'b0;
		`CHK("rdata", (a == STARTUP_TWO_OFFSET) ? modelWord : 32'h00000000, rd)
		`CHK("rresp", (a == STARTUP_TWO_OFFSET) ? RESP_OKAY : RESP_SLVERR, rs)
	endtask : axi_read
	task automatic chk_dec;
		int c;
		int e;
		@(negedge sys_clk);
		c = modelWord[30:27];
		e = c < 4 ? 125 << c : c < 14 ? 1500 + 500 * (c - 4) : c == 14 ? 7000 : 8000;
		`CHK("parity", modelWord[31], parityBit)
		`CHK("cap", e, openLoopCurrentCapMilliamp)
		`CHK("lin", accTab[modelWord[26:23]], openLoopAccelLinearCenti)
		`CHK("quad", modelWord[22:19] == 0 ? 0 : accTab[modelWord[22:19]], openLoopAccelQuadraticCenti)
		`CHK("auto", modelWord[18], autoHandoffEn)
		`CHK("thrEn", !modelWord[18], thresholdHandoffEn)
		`CHK("thr", modelWord[17:13], loopTransferSpeedThreshold)
		@(posedge sys_clk);
	endtask : chk_dec
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		chk_dec;
		axi_read(STARTUP_TWO_OFFSET);
		// Every code of the cap and accel fields, odd threshold codes only, mode bit toggling
		for (int i = 0; i < 16; i++) begin
			r = xs();
			axi_write(STARTUP_TWO_OFFSET, {i[0], i[3:0], 4'(15 - i), i[3:0], i[1], 5'(i * 2 + 1), r[12:0]}, 4'hF);
			chk_dec;
			axi_read(STARTUP_TWO_OFFSET);
		end
		// Random words and byte enables, unmapped places mixed in
		for (int i = 0; i < 40; i++) begin
			r = xs();
			axi_write((i % 5 == 4) ? r[9:0] : STARTUP_TWO_OFFSET, xs(), r[13:10]);
			chk_dec;
			axi_read((i % 7 == 3) ? {r[31:24], 2'b00} : STARTUP_TWO_OFFSET);
		end
		// Mid-run reset must clear the stored word and return every decoded value to its code-zero value
		rst <= 1'b1;
		modelWord = 32'h00000000;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		chk_dec;
		axi_read(STARTUP_TWO_OFFSET);
		// Neighbouring words and the bare index used as a byte address all miss
		axi_write(STARTUP_TWO_OFFSET + 10'h004, 32'hFFFFFFFF, 4'hF);
		axi_read(STARTUP_TWO_OFFSET + 10'h004);
		chk_dec;
		axi_read(ADDR_W'(STARTUP_TWO_INDEX));
		chk_dec;
		axi_read(STARTUP_TWO_OFFSET - 10'h004);
		chk_dec;
		wrap_up;
	end
endmodule : tb
`default_nettype wire
